// *** logic/isamw_params.svh ***
`ifndef ISAMW_PARAMS_SVH
`define ISAMW_PARAMS_SVH

// register byte offsets
`define ISAMW_OFS_RXDATA   8'h34
`define ISAMW_OFS_OWN0     8'h44
`define ISAMW_OFS_OWN1     8'h48
`define ISAMW_OFS_MASK0    8'h4C
`define ISAMW_OFS_MASK1    8'h50
`define ISAMW_OFS_WKCTL    8'h54
`define ISAMW_OFS_WKSTS    8'h58
`define ISAMW_OFS_MATCH    8'h5C

// field positions
`define ISAMW_BIT_WAKE_EN  0
`define ISAMW_BIT_WKSEL    1
`define ISAMW_BIT_WKFLAG   0
`define ISAMW_BIT_TENEN    4

// reset values and encodings
`define ISAMW_RST_REG      32'h00000000
`define ISAMW_SLOTS        2
`define ISAMW_ADDR_BITS    10
`define ISAMW_TEN_HDR      5'h1E
`define ISAMW_LAST_BIT     4'h7
`define ISAMW_RESP_OKAY    2'h0
`define ISAMW_RESP_SLVERR  2'h2

`endif

// *** logic/isamw_pkg.sv ***
`include "isamw_params.svh"

package isamw_pkg;

    typedef enum logic [1:0] {
        ls_idle = 2'b00,
        ls_byte = 2'b01,
        ls_ack  = 2'b10
    } isamw_lstate_t;

    typedef struct packed {
        logic          rst_s1;
        logic          rst_s2;
        logic          scl_s1;
        logic          scl_s2;
        logic          scl_d;
        logic          sda_s1;
        logic          sda_s2;
        logic          sda_d;
        isamw_lstate_t st;
        logic [3:0]    cnt;
        logic [7:0]    shreg;
        logic [7:0]    byte_q;
        logic          first_pend;
        logic          first_q;
        logic          btog;
        logic          dtog;
    } isamw_link_t;

    typedef struct packed {
        logic [`ISAMW_SLOTS-1:0][`ISAMW_ADDR_BITS-1:0] own;
        logic [`ISAMW_SLOTS-1:0][`ISAMW_ADDR_BITS-1:0] msk;
        logic                    wk_en;
        logic                    wk_sel;
        logic                    ten_en;
        logic                    wk_flag;
        logic [7:0]              rxbuf;
        logic                    tg_s1;
        logic                    tg_s2;
        logic                    tg_s3;
        logic                    dt_s1;
        logic                    dt_s2;
        logic                    dt_s3;
        logic [`ISAMW_SLOTS-1:0] pend;
        logic                    hit;
        logic                    slot;
        logic                    wake_req;
        logic                    aw_got;
        logic [7:0]              awaddr;
        logic                    w_got;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
    } isamw_core_t;

endpackage

// *** logic/isamw_link.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "isamw_params.svh"

module isamw_link
    import isamw_pkg::*;
(
    // link clock and reset
    input  wire logic       link_clk,
    input  wire logic       aresetn,
    // bus lines
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    // towards the core, held stable between toggles
    output logic [7:0]      rx_byte,
    output logic            rx_first,
    output logic            rx_toggle,
    output logic            sda_toggle
);

    isamw_link_t link_ff;
    isamw_link_t nxt_link;
    logic        scl_rise;
    logic        start_ev;
    logic        stop_ev;

    always_comb begin
        nxt_link = link_ff;
        nxt_link.rst_s1 = aresetn;
        nxt_link.rst_s2 = link_ff.rst_s1;
        nxt_link.scl_s1 = scl_in;
        nxt_link.scl_s2 = link_ff.scl_s1;
        nxt_link.scl_d  = link_ff.scl_s2;
        nxt_link.sda_s1 = sda_in;
        nxt_link.sda_s2 = link_ff.sda_s1;
        nxt_link.sda_d  = link_ff.sda_s2;
        scl_rise = link_ff.scl_s2 & ~link_ff.scl_d;
        start_ev = link_ff.scl_s2 & link_ff.scl_d & link_ff.sda_d & ~link_ff.sda_s2;
        stop_ev  = link_ff.scl_s2 & link_ff.scl_d & ~link_ff.sda_d & link_ff.sda_s2;
        if (link_ff.sda_s2 != link_ff.sda_d) begin
            nxt_link.dtog = ~link_ff.dtog;
        end
        case (link_ff.st)
            ls_idle: begin
            end
            ls_byte: begin
                if (scl_rise) begin
                    nxt_link.shreg = {link_ff.shreg[6:0], link_ff.sda_s2};
                    nxt_link.cnt   = link_ff.cnt + 4'h1;
                    if (link_ff.cnt == `ISAMW_LAST_BIT) begin
                        // byte and marker change together, well before the toggle is seen
                        nxt_link.byte_q     = {link_ff.shreg[6:0], link_ff.sda_s2};
                        nxt_link.first_q    = link_ff.first_pend;
                        nxt_link.first_pend = 1'h0;
                        nxt_link.btog       = ~link_ff.btog;
                        nxt_link.st         = ls_ack;
                    end
                end
            end
            ls_ack: begin
                if (scl_rise) begin
                    nxt_link.cnt = 4'h0;
                    nxt_link.st  = ls_byte;
                end
            end
            default: begin
                nxt_link.st = ls_idle;
            end
        endcase
        // repeated start restarts the address phase
        if (start_ev) begin
            nxt_link.st         = ls_byte;
            nxt_link.cnt        = 4'h0;
            nxt_link.first_pend = 1'h1;
        end else if (stop_ev) begin
            nxt_link.st = ls_idle;
        end
        if (!link_ff.rst_s2) begin
            nxt_link        = '0;
            nxt_link.rst_s1 = aresetn;
            nxt_link.rst_s2 = link_ff.rst_s1;
            // idle bus is high; a zero here would fake an edge after reset
            nxt_link.scl_s1 = 1'h1;
            nxt_link.scl_s2 = 1'h1;
            nxt_link.scl_d  = 1'h1;
            nxt_link.sda_s1 = 1'h1;
            nxt_link.sda_s2 = 1'h1;
            nxt_link.sda_d  = 1'h1;
        end
    end

    always_ff @(posedge link_clk) begin
        link_ff <= nxt_link;
    end

    assign rx_byte    = link_ff.byte_q;
    assign rx_first   = link_ff.first_q;
    assign rx_toggle  = link_ff.btog;
    assign sda_toggle = link_ff.dtog;

endmodule

`default_nettype wire

// *** logic/isamw_top.sv ***
// Behaviour
// - received data readable, bits above 7 zero
// - received byte sits in bits 7:0
// - two writable 10-bit own addresses
// - 10-bit header bits compared with address 9:8
// - second byte compared with address 7:0
// - 7-bit mode compares address bits 6:0 only
// - mask one is don't-care, zero exact
// - two independent 10-bit mask registers
// - wake enable gates every wake request
// - wake source: data toggle or address match
// - wake sets sticky wake flag
// - write one clears flag, zero keeps it
// - ten-bit enable selects 10-bit matching
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "isamw_params.svh"

module isamw_top
    import isamw_pkg::*;
(
    // system clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // bus side
    input  wire logic        link_clk,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // power management
    input  wire logic        power_down,
    output logic             wake_request,
    // match results
    output logic             address_hit,
    output logic             hit_slot
);

    isamw_core_t             core_ff;
    isamw_core_t             nxt_core;
    logic [7:0]              rx_byte;
    logic                    rx_first;
    logic                    rx_toggle;
    logic                    sda_toggle;
    logic                    byte_ev;
    logic                    data_ev;
    logic                    do_write;
    logic                    hit_now;
    logic                    wake_now;
    logic [`ISAMW_SLOTS-1:0] m7;
    logic [`ISAMW_SLOTS-1:0] mhi;
    logic [`ISAMW_SLOTS-1:0] mlo;
    logic [`ISAMW_SLOTS-1:0] hitv;

    isamw_link u_link (
        .link_clk   (link_clk),
        .aresetn    (aresetn),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .rx_byte    (rx_byte),
        .rx_first   (rx_first),
        .rx_toggle  (rx_toggle),
        .sda_toggle (sda_toggle)
    );

    function automatic logic [9:0] merge10(input logic [9:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0] strb);
        merge10 = {strb[1] ? wd[9:8] : old_v[9:8], strb[0] ? wd[7:0] : old_v[7:0]};
    endfunction

    // toggle edges; the third stage only serves the edge detect
    assign byte_ev = core_ff.tg_s2 ^ core_ff.tg_s3;
    assign data_ev = core_ff.dt_s2 ^ core_ff.dt_s3;

    generate
        for (genvar gi = 0; gi < `ISAMW_SLOTS; gi++) begin : g_slot
            assign m7[gi]  = &(~(rx_byte[7:1] ^ core_ff.own[gi][6:0])
                               | core_ff.msk[gi][6:0]);
            assign mhi[gi] = (rx_byte[7:3] == `ISAMW_TEN_HDR)
                             && (&(~(rx_byte[2:1] ^ core_ff.own[gi][9:8])
                                   | core_ff.msk[gi][9:8]));
            assign mlo[gi] = &(~(rx_byte ^ core_ff.own[gi][7:0])
                               | core_ff.msk[gi][7:0]);
        end
    endgenerate

    assign s_axi_awready = ce & ~core_ff.aw_got & ~core_ff.bvalid;
    assign s_axi_wready  = ce & ~core_ff.w_got & ~core_ff.bvalid;
    assign s_axi_arready = ce & ~core_ff.rvalid;
    assign do_write      = core_ff.aw_got & core_ff.w_got & ~core_ff.bvalid;

    always_comb begin
        nxt_core       = core_ff;
        nxt_core.tg_s1 = rx_toggle;
        nxt_core.tg_s2 = core_ff.tg_s1;
        nxt_core.tg_s3 = core_ff.tg_s2;
        nxt_core.dt_s1 = sda_toggle;
        nxt_core.dt_s2 = core_ff.dt_s1;
        nxt_core.dt_s3 = core_ff.dt_s2;

        // address phase; link data is held stable across the toggle crossing
        hit_now = 1'h0;
        hitv    = '0;
        if (byte_ev) begin
            nxt_core.rxbuf = rx_byte;
            if (rx_first) begin
                if (core_ff.ten_en) begin
                    nxt_core.pend = mhi;
                end else begin
                    nxt_core.pend = '0;
                    hitv          = m7;
                    hit_now       = |m7;
                end
            end else begin
                // only the byte right after a matching header can complete it
                hitv          = core_ff.pend & mlo;
                hit_now       = |hitv;
                nxt_core.pend = '0;
            end
        end
        nxt_core.hit = hit_now;
        if (hit_now) begin
            nxt_core.slot = ~hitv[0];
        end

        // wake decision
        wake_now = core_ff.wk_en & power_down
                   & (core_ff.wk_sel ? hit_now : data_ev);
        nxt_core.wake_req = wake_now;

        // write channels, either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_core.aw_got = 1'h1;
            nxt_core.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_core.w_got = 1'h1;
            nxt_core.wdata = s_axi_wdata;
            nxt_core.wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_core.aw_got = 1'h0;
            nxt_core.w_got  = 1'h0;
            nxt_core.bvalid = 1'h1;
            nxt_core.bresp  = `ISAMW_RESP_OKAY;
            case (core_ff.awaddr)
                `ISAMW_OFS_RXDATA: begin
                end
                `ISAMW_OFS_OWN0: begin
                    nxt_core.own[0] = merge10(core_ff.own[0], core_ff.wdata,
                                              core_ff.wstrb);
                end
                `ISAMW_OFS_OWN1: begin
                    nxt_core.own[1] = merge10(core_ff.own[1], core_ff.wdata,
                                              core_ff.wstrb);
                end
                `ISAMW_OFS_MASK0: begin
                    nxt_core.msk[0] = merge10(core_ff.msk[0], core_ff.wdata,
                                              core_ff.wstrb);
                end
                `ISAMW_OFS_MASK1: begin
                    nxt_core.msk[1] = merge10(core_ff.msk[1], core_ff.wdata,
                                              core_ff.wstrb);
                end
                `ISAMW_OFS_WKCTL: begin
                    if (core_ff.wstrb[0]) begin
                        nxt_core.wk_en  = core_ff.wdata[`ISAMW_BIT_WAKE_EN];
                        nxt_core.wk_sel = core_ff.wdata[`ISAMW_BIT_WKSEL];
                    end
                end
                `ISAMW_OFS_WKSTS: begin
                    if (core_ff.wstrb[0] && core_ff.wdata[`ISAMW_BIT_WKFLAG]) begin
                        nxt_core.wk_flag = 1'h0;
                    end
                end
                `ISAMW_OFS_MATCH: begin
                    if (core_ff.wstrb[0]) begin
                        nxt_core.ten_en = core_ff.wdata[`ISAMW_BIT_TENEN];
                    end
                end
                default: begin
                    nxt_core.bresp = `ISAMW_RESP_SLVERR;
                end
            endcase
        end
        if (core_ff.bvalid && s_axi_bready) begin
            nxt_core.bvalid = 1'h0;
        end

        // a wake in the same cycle as the clear keeps the flag set
        if (core_ff.wake_req) begin
            nxt_core.wk_flag = 1'h1;
        end

        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_core.rvalid = 1'h1;
            nxt_core.rresp  = `ISAMW_RESP_OKAY;
            nxt_core.rdata  = `ISAMW_RST_REG;
            case (s_axi_araddr)
                `ISAMW_OFS_RXDATA: begin
                    nxt_core.rdata[7:0] = core_ff.rxbuf;
                end
                `ISAMW_OFS_OWN0: begin
                    nxt_core.rdata[9:0] = core_ff.own[0];
                end
                `ISAMW_OFS_OWN1: begin
                    nxt_core.rdata[9:0] = core_ff.own[1];
                end
                `ISAMW_OFS_MASK0: begin
                    nxt_core.rdata[9:0] = core_ff.msk[0];
                end
                `ISAMW_OFS_MASK1: begin
                    nxt_core.rdata[9:0] = core_ff.msk[1];
                end
                `ISAMW_OFS_WKCTL: begin
                    nxt_core.rdata[`ISAMW_BIT_WAKE_EN] = core_ff.wk_en;
                    nxt_core.rdata[`ISAMW_BIT_WKSEL] = core_ff.wk_sel;
                end
                `ISAMW_OFS_WKSTS: begin
                    nxt_core.rdata[`ISAMW_BIT_WKFLAG] = core_ff.wk_flag;
                end
                `ISAMW_OFS_MATCH: begin
                    nxt_core.rdata[`ISAMW_BIT_TENEN] = core_ff.ten_en;
                end
                default: begin
                    nxt_core.rresp = `ISAMW_RESP_SLVERR;
                end
            endcase
        end else if (core_ff.rvalid && s_axi_rready) begin
            nxt_core.rvalid = 1'h0;
        end

        // frozen enable also freezes the crossings, so one toggle during the freeze is still seen after it; an even number of toggles leaves no edge
        if (!ce) begin
            nxt_core = core_ff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_ff <= '0;
        end else begin
            core_ff <= nxt_core;
        end
    end

    assign s_axi_bresp  = core_ff.bresp;
    assign s_axi_bvalid = core_ff.bvalid;
    assign s_axi_rdata  = core_ff.rdata;
    assign s_axi_rresp  = core_ff.rresp;
    assign s_axi_rvalid = core_ff.rvalid;
    assign wake_request = core_ff.wake_req;
    assign address_hit  = core_ff.hit;
    assign hit_slot     = core_ff.slot;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_rx_read_word: assert property (
        (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == `ISAMW_OFS_RXDATA)
        |=> (s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000
             && s_axi_rdata[7:0] == $past(core_ff.rxbuf)))
        else $error("received data read returned wrong word");

    chk_rx_byte_store: assert property (
        (ce && byte_ev) |=> (core_ff.rxbuf == $past(rx_byte)))
        else $error("received byte not stored");

    chk_own_write_full: assert property (
        (ce && do_write && core_ff.awaddr == `ISAMW_OFS_OWN1 && core_ff.wstrb == 4'hF)
        |=> (core_ff.own[1] == $past(core_ff.wdata[9:0]) && s_axi_bvalid))
        else $error("own address write lost");

    chk_ten_first_nohit: assert property (
        (ce && byte_ev && rx_first && core_ff.ten_en)
        |=> (!address_hit && core_ff.pend == $past(mhi)))
        else $error("ten-bit header handled wrongly");

    chk_ten_second_hit: assert property (
        (ce && byte_ev && !rx_first && core_ff.pend[0] && mlo[0])
        |=> (address_hit && !hit_slot))
        else $error("ten-bit second byte missed");

    chk_seven_bit_hit: assert property (
        (ce && byte_ev && rx_first && !core_ff.ten_en
         && ((rx_byte[7:1] ^ core_ff.own[0][6:0]) & ~core_ff.msk[0][6:0]) == 7'h00)
        |=> (address_hit && !hit_slot))
        else $error("seven-bit address not matched");

    chk_mask_dont_care: assert property (
        (ce && byte_ev && rx_first && !core_ff.ten_en && core_ff.msk[1][6:0] == 7'h7F)
        |=> address_hit)
        else $error("fully masked slot did not hit");

    chk_no_stray_hit: assert property (
        (ce && byte_ev && rx_first && !core_ff.ten_en && m7 == 2'h0)
        |=> !address_hit)
        else $error("hit without any matching slot");

    chk_wake_gated: assert property (
        (!core_ff.wk_en && !$past(core_ff.wk_en)) |-> !wake_request)
        else $error("wake requested while disabled");

    // a frozen enable may delay the flag, so it is excused then
    logic wake_flag_set_seen;
    assign wake_flag_set_seen = core_ff.wk_flag | ~ce;

    chk_wake_toggle: assert property (
        (ce && core_ff.wk_en && !core_ff.wk_sel && power_down && data_ev)
        |=> wake_request ##1 wake_flag_set_seen)
        else $error("data toggle did not wake");

    chk_flag_sticky: assert property (
        (ce && wake_request) |=> core_ff.wk_flag)
        else $error("wake flag not set");

    chk_flag_w0_keeps: assert property (
        (ce && do_write && core_ff.awaddr == `ISAMW_OFS_WKSTS && !core_ff.wdata[0])
        |=> (core_ff.wk_flag == ($past(core_ff.wk_flag) | $past(core_ff.wake_req))))
        else $error("zero write changed wake flag");

endmodule

`default_nettype wire

// *** verif/isamw_i2c_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module isamw_i2c_ctrl #(
    parameter int HALF = 300
) (
    // bus lines, released level is high
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // scl stands high between frames; the ack slot is left to the pull-up
    task automatic frame(input logic [15:0] q, input int n);
        logic [8:0] sh;
        sda = 1'b0;
        #HALF scl = 1'b0;
        for (int i = 0; i < n; i++) begin
            sh = {q[15 - 8 * i -: 8], 1'b1};
            for (int b = 8; b >= 0; b--) begin
                sda = sh[b];
                #HALF scl = 1'b1;
                #HALF scl = 1'b0;
            end
        end
        sda = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda = 1'b1;
        #HALF;
    endtask
endmodule

`default_nettype wire

// *** verif/i2c_slave_address_match_wake_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "isamw_params.svh"

module i2c_slave_address_match_wake_tb;
    logic        aclk = 1'b0;
    logic        link_clk = 1'b0;
    logic        aresetn = 1'b0;
    logic        power_down = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, scl, sda;
    logic        wake_request, address_hit, hit_slot, slot_seen;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata, rdv;
    logic [9:0]  own [2];
    logic [9:0]  msk [2];
    logic [7:0]  b1, b2;
    int          fails = 0, samples_checked = 0, hits = 0, wakes = 0, cyc = 0, k, w0;
    bit          flag_exp;

    always #12.5 aclk = ~aclk;
    always #15 link_clk = ~link_clk;

    isamw_top dut (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda), .power_down(power_down),
        .wake_request(wake_request), .address_hit(address_hit), .hit_slot(hit_slot));

    isamw_i2c_ctrl bus (.scl(scl), .sda(sda));

    task automatic finish_test;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        if (address_hit === 1'b1) begin
            hits <= hits + 1;
            slot_seen <= hit_slot;
        end
        if (wake_request === 1'b1) wakes <= wakes + 1;
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // readies are taken from the negedge, where inputs are already settled
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid;
            rdv = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_write(a, d, 4'hF);
        chk(rsp, `ISAMW_RESP_OKAY);
    endtask

    function automatic logic [7:0] flip8();
        return ($urandom % 2) ? 8'h00 : 8'h01 << ($urandom % 8);
    endfunction

    // slot 0 first, so it wins when both addresses accept the byte
    function automatic int exp_slot(input bit ten);
        for (int s = 0; s < 2; s++) begin
            if (!ten && ((b1[7:1] ^ own[s][6:0]) & ~msk[s][6:0]) == 7'h00) return s;
            if (ten && b1[7:3] == `ISAMW_TEN_HDR && ((b1[2:1] ^ own[s][9:8]) & ~msk[s][9:8]) == 2'h0
                && ((b2 ^ own[s][7:0]) & ~msk[s][7:0]) == 8'h00) return s;
        end
        return -1;
    endfunction

    task automatic send_check(input bit ten);
        int e, h0;
        e = exp_slot(ten);
        h0 = hits;
        bus.frame({b1, b2}, ten ? 2 : 1);
        repeat (10) @(posedge aclk);
        chk(hits - h0, e >= 0);
        if (e >= 0) chk(slot_seen, e[0]);
        axi_read(`ISAMW_OFS_RXDATA);
        chk(rdv, ten ? b2 : b1);
    endtask

    task automatic program_slots(input int n);
        for (int s = 0; s < 2; s++) begin
            own[s] = 10'($urandom);
            msk[s] = 10'($urandom & $urandom & $urandom);
            wr(s ? `ISAMW_OFS_OWN1 : `ISAMW_OFS_OWN0, {22'h0, own[s]});
            wr(s ? `ISAMW_OFS_MASK1 : `ISAMW_OFS_MASK0, {22'h0, msk[s]});
            axi_read(s ? `ISAMW_OFS_OWN1 : `ISAMW_OFS_OWN0);
            chk(rdv, {22'h0, own[s]});
            axi_read(s ? `ISAMW_OFS_MASK1 : `ISAMW_OFS_MASK0);
            chk(rdv, {22'h0, msk[s]});
        end
        k = $urandom % n;
    endtask

    logic [7:0] ofs [8] = '{`ISAMW_OFS_RXDATA, `ISAMW_OFS_OWN0, `ISAMW_OFS_OWN1,
        `ISAMW_OFS_MASK0, `ISAMW_OFS_MASK1, `ISAMW_OFS_WKCTL, `ISAMW_OFS_WKSTS, `ISAMW_OFS_MATCH};

    initial begin
        void'($urandom(32'h31d47fcf));
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
        foreach (ofs[i]) begin
            axi_read(ofs[i]);
            chk(rdv, `ISAMW_RST_REG);
        end
        axi_write(8'h60, 32'hFFFFFFFF, 4'hF);
        chk(rsp, `ISAMW_RESP_SLVERR);
        axi_read(8'h45);
        chk(rsp, `ISAMW_RESP_SLVERR);
        wr(`ISAMW_OFS_RXDATA, 32'hFFFFFFFF);
        axi_read(`ISAMW_OFS_RXDATA);
        chk(rdv, 32'h0);
        for (int r = 0; r < 12; r++) begin
            program_slots(2);
            // last round: slot 1 takes any 7-bit address
            if (r == 11) begin
                msk[1] = 10'h07F;
                wr(`ISAMW_OFS_MASK1, 32'h7F);
            end
            b1 = {own[k][6:0], 1'($urandom)} ^ (flip8() & 8'hFE);
            send_check(1'b0);
        end
        wr(`ISAMW_OFS_MATCH, 32'h10);
        repeat (10) begin
            program_slots(2);
            b1 = {`ISAMW_TEN_HDR, own[k][9:8], 1'b0} ^ (flip8() & 8'h06);
            b2 = own[k][7:0] ^ flip8();
            send_check(1'b1);
        end
        wr(`ISAMW_OFS_MATCH, 32'h0);
        msk[0] = 10'h000;
        wr(`ISAMW_OFS_MASK0, 32'h0);
        b1 = {own[0][6:0], 1'b0};
        @(posedge aclk);
        power_down <= 1'b1;
        flag_exp = 1'b0;
        for (int m = 0; m < 4; m++) begin
            wr(`ISAMW_OFS_WKCTL, 32'(m));
            w0 = wakes;
            send_check(1'b0);
            chk(wakes != w0, m[0]);
            if (m == 3) chk(wakes - w0, 1);
            flag_exp = flag_exp | m[0];
            axi_read(`ISAMW_OFS_WKSTS);
            chk(rdv, 32'(flag_exp));
        end
        wr(`ISAMW_OFS_WKSTS, 32'h0);
        axi_read(`ISAMW_OFS_WKSTS);
        chk(rdv, 32'h1);
        wr(`ISAMW_OFS_WKSTS, 32'h1);
        axi_read(`ISAMW_OFS_WKSTS);
        chk(rdv, 32'h0);
        finish_test();
    end
endmodule

`default_nettype wire
